// [hw/root_hub_port_descriptor_b_regs.svh]
`ifndef ROOT_HUB_PORT_DESCRIPTOR_B_REGS_SVH
`define ROOT_HUB_PORT_DESCRIPTOR_B_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RHPDB_READ_CODE 8'h13
`define RHPDB_WRITE_CODE 8'h93
`define RHPDB_CTRL_READ_CODE 8'h20
`define RHPDB_CTRL_WRITE_CODE 8'hA0
`define RHPDB_STAT_READ_CODE 8'h21
`define RHPDB_STAT_WRITE_CODE 8'hA1

// ==========================================================================
// Field positions
`define RHPDB_MASK_LSB 16
`define RHPDB_MASK_MSB 18
`define RHPDB_FIXED_LSB 0
`define RHPDB_FIXED_MSB 2
`define RHPDB_CTRL_SELECT_BIT 0
`define RHPDB_STAT_SET_GLOBAL_BIT 0
`define RHPDB_STAT_CLR_GLOBAL_BIT 1
`define RHPDB_STAT_SET_PORT_LSB 4
`define RHPDB_STAT_CLR_PORT_LSB 8

// ==========================================================================
// Reset values and the mask of used port bits
`define RHPDB_MASK_RESET 3'h0
`define RHPDB_FIXED_RESET 3'h0
`define RHPDB_PORT_USED 3'h6

`endif

// [hw/rhpdb_pkg.sv]
package rhpdb_pkg;

  // ==========================================================================
  // Per-port bit vector, bit 0 unused
  typedef logic [2:0] port_vec_t;

  // Bus answer phase
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage : rhpdb_pkg

// [hw/port_power_cell.sv]
`timescale 1ns/100ps

// ==========================================================================
// One downstream port's power state
module port_power_cell (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controls
  input wire logic per_port_switch_select_i,
  input wire logic port_power_mask_i,
  input wire logic global_set_i,
  input wire logic global_clr_i,
  input wire logic port_set_i,
  input wire logic port_clr_i,
  // State
  output logic port_power_state_o
);

  typedef struct packed {
    logic power;
  } cell_s;

  cell_s q, d;

  // Route global or per-port commands; set beats clear on collision
  always_comb
  begin
    d = q;
    if (!per_port_switch_select_i)
    begin
      // Mask ignored in global switching mode
      if (global_set_i) d.power = 1'b1;
      else if (global_clr_i) d.power = 1'b0;
    end
    else if (port_power_mask_i)
    begin
      if (port_set_i) d.power = 1'b1;
      else if (port_clr_i) d.power = 1'b0;
    end
    else
    begin
      if (global_set_i) d.power = 1'b1;
      else if (global_clr_i) d.power = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i) q <= '0;
    else q <= d;
  end

  assign port_power_state_o = q.power;

endmodule : port_power_cell

// [hw/root_hub_port_descriptor_b.sv]
// Contract
// - Index 13h reads the descriptor; index 93h writes its writable fields.
// - Reset values of mask and fixed flags are parameters chosen per system.
// - Bits 18:16 are the power mask; set bit means per-port commands only.
// - Clear mask bit means the port follows only global power commands.
// - With per-port selection zero, mask is ignored; all follow global commands.
// - Mask bit 0 reserved, bit 1 is port one, bit 2 port two.
// - Bits 2:0 flag fixed devices; zero removable, one non-removable.
// - Fixed flag bit 0 reserved, bit 1 port one, bit 2 port two.
// - Bits 31:19 and 15:3 are reserved and read-only.
// - Per-port selection one powers each port individually per its mask.
// - In per-port mode global commands affect only unmasked ports.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "root_hub_port_descriptor_b_regs.svh"

module root_hub_port_descriptor_b #(
  parameter logic [2:0] MASK_RESET = `RHPDB_MASK_RESET,
  parameter logic [2:0] FIXED_RESET = `RHPDB_FIXED_RESET
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Port state
  output logic [2:1] port_power_state_o,
  output logic [2:1] attached_device_fixed_o,
  output logic per_port_switch_select_o
);

  // ==========================================================================
  // Index map of this block (byte address is four times the index)
  //   13h read / 93h write: descriptor, mask in bits 18:16, fixed flags in 2:0
  //   20h read / A0h write: control, bit 0 selects per-port switching
  //   21h read: power state of port one and two in bits 2:1
  //   A1h write: power commands, write one to fire
  //     bit 0 global set, bit 1 global clear
  //     bits 6:5 set port one/two, bits 10:9 clear port one/two
  // Bit 0 of each per-port field has no port behind it, so it is never stored;
  // software that writes ones there reads zeros back.
  // The control and command indices stand in for the hub's mode bit and its
  // global command register, which live elsewhere in a full controller;
  // only the commands and the selection matter to this block.

  // ==========================================================================
  // State
  typedef struct packed {
    // Bus answer
    rhpdb_pkg::bus_state_e bus;
    logic [31:0] rdata;
    // Stored fields
    rhpdb_pkg::port_vec_t port_power_mask;
    rhpdb_pkg::port_vec_t device_fixed_flags;
    logic switch_select_bit;
    // One-cycle command pulses toward the cells, then the registered mirror of the cell states
    logic set_global;
    logic clr_global;
    rhpdb_pkg::port_vec_t set_port;
    rhpdb_pkg::port_vec_t clr_port;
    logic [2:1] power;
  } regs_s;

  regs_s q, d;
  logic [2:1] power_w;
  logic [7:0] index_w;
  logic access_w;

  // Byte address is four times the index
  assign index_w = adr_i[9:2];
  assign access_w = cyc_i && stb_i && (q.bus == rhpdb_pkg::BUS_IDLE);

  // ==========================================================================
  // Register file and command pulses
  // A request held past its ack is not taken again while ack stands,
  // so a master that drops its strobe late still sees one answer.
  always_comb
  begin
    d = q;
    // Command strobes default low: a write of one fires exactly one pulse
    d.set_global = 1'b0;
    d.clr_global = 1'b0;
    d.set_port = 3'h0;
    d.clr_port = 3'h0;
    // Mirror of the cell states, one cycle behind them
    d.power = power_w;
    d.bus = rhpdb_pkg::BUS_IDLE; // Ack lasts one cycle
    if (access_w)
    begin
      d.bus = rhpdb_pkg::BUS_ACK;
      d.rdata = 32'h0000_0000; // Unmapped and reserved read zero
      if (!we_i)
      begin
        // Read: the answer is registered and stands until the next access
        unique case (index_w)
          `RHPDB_READ_CODE:
          begin
            // Reserved bits stay zero
            d.rdata[`RHPDB_MASK_MSB:`RHPDB_MASK_LSB] = q.port_power_mask;
            d.rdata[`RHPDB_FIXED_MSB:`RHPDB_FIXED_LSB] = q.device_fixed_flags;
          end
          `RHPDB_CTRL_READ_CODE:
          begin
            // Switching selection, all other bits zero
            d.rdata[`RHPDB_CTRL_SELECT_BIT] = q.switch_select_bit;
          end
          `RHPDB_STAT_READ_CODE:
          begin
            // Port power states in their port bit positions
            d.rdata[2:1] = q.power;
          end
          default:
          begin
            // Unmapped index still answers, with zero
            d.rdata = 32'h0000_0000;
          end
        endcase
      end
      else
      begin
        // Write: fields change at the taking edge, the same edge that raises ack
        unique case (index_w)
          `RHPDB_WRITE_CODE:
          begin
            // Only port bits are stored; bit 0 and reserved dropped
            if (sel_i[2])
            begin
              // Mask lives in byte lane 2
              d.port_power_mask = dat_i[`RHPDB_MASK_MSB:`RHPDB_MASK_LSB]
                                  & `RHPDB_PORT_USED;
            end
            if (sel_i[0])
            begin
              // Fixed flags live in byte lane 0
              d.device_fixed_flags = dat_i[`RHPDB_FIXED_MSB:`RHPDB_FIXED_LSB]
                                     & `RHPDB_PORT_USED;
            end
          end
          `RHPDB_CTRL_WRITE_CODE:
          begin
            // A new selection applies from the next command on
            if (sel_i[0])
            begin
              d.switch_select_bit = dat_i[`RHPDB_CTRL_SELECT_BIT];
            end
          end
          `RHPDB_STAT_WRITE_CODE:
          begin
            // Both low lanes needed, so a partial write cannot fire half a command
            if (sel_i[1] && sel_i[0])
            begin
              // Writing one fires the command, zero has no effect
              d.set_global = dat_i[`RHPDB_STAT_SET_GLOBAL_BIT];
              d.clr_global = dat_i[`RHPDB_STAT_CLR_GLOBAL_BIT];
              d.set_port = dat_i[`RHPDB_STAT_SET_PORT_LSB +: 3] & `RHPDB_PORT_USED;
              d.clr_port = dat_i[`RHPDB_STAT_CLR_PORT_LSB +: 3] & `RHPDB_PORT_USED;
            end
          end
          default:
          begin
            // Unmapped write ignored, still acked so the master never hangs
            d.set_global = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Registers; mask and fixed flag reset values are system parameters
  // Bit 0 is masked off here too, whatever value the parameter carries
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.port_power_mask <= MASK_RESET & `RHPDB_PORT_USED;
      q.device_fixed_flags <= FIXED_RESET & `RHPDB_PORT_USED;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // Per-port power cells
  // Port zero has no cell: bit 0 of each vector is reserved
  genvar p;
  generate
    for (p = 1; p <= 2; p++)
    begin : g_port
      port_power_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .per_port_switch_select_i(q.switch_select_bit),
        .port_power_mask_i(q.port_power_mask[p]),
        .global_set_i(q.set_global),
        .global_clr_i(q.clr_global),
        .port_set_i(q.set_port[p]),
        .port_clr_i(q.clr_port[p]),
        .port_power_state_o(power_w[p])
      );
    end
  endgenerate

  // Outputs all from flip-flops
  assign dat_o = q.rdata;
  assign ack_o = (q.bus == rhpdb_pkg::BUS_ACK);
  assign port_power_state_o = q.power;
  assign attached_device_fixed_o = q.device_fixed_flags[2:1];
  assign per_port_switch_select_o = q.switch_select_bit;

endmodule : root_hub_port_descriptor_b

// [dv/rhpdb_checker.sv]
`timescale 1ns/100ps
// ==========================================
// Port relations of the descriptor block
module rhpdb_checker (
  // Bus side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Port side
  input wire logic [2:1] port_power_state_o,
  input wire logic [2:1] attached_device_fixed_o,
  input wire logic per_port_switch_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Handshake: one answer, one cycle after the taking edge
  a_ack_on_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  // Reserved bits and bit 0 of both fields read zero
  a_reserved_zero: assert property (ack_o && $past(!we_i && adr_i[9:2] == 8'h13)
    |-> (dat_o & 32'hFFF9_FFF9) == 32'h0) else $error("reserved bit set");
  // Reset is checked during reset itself, so it overrides the default disable
  a_reset_clear: assert property (disable iff (1'b0) rst_i
    |=> !ack_o && port_power_state_o == 2'h0 && !per_port_switch_select_o) else $error("reset");
  a_flags_out: assert property (ack_o && $past(we_i && adr_i[9:2] == 8'h93 && sel_i[0])
    |=> attached_device_fixed_o == $past(dat_i[2:1], 2)) else $error("flag output");
  a_select_out: assert property (ack_o && $past(we_i && adr_i[9:2] == 8'hA0 && sel_i[0])
    |=> per_port_switch_select_o == $past(dat_i[0], 2)) else $error("select output");
  a_power_cause: assert property ($changed(port_power_state_o)
    |-> $past(ack_o, 2) || $past(ack_o, 3) || $past(ack_o, 4)) else $error("power moved");
  // Main scenarios
  c_desc_write: cover property (ack_o && $past(we_i && adr_i[9:2] == 8'h93));
  c_desc_read: cover property (ack_o && $past(!we_i && adr_i[9:2] == 8'h13));
  c_power_move: cover property ($changed(port_power_state_o));
endmodule : rhpdb_checker

bind root_hub_port_descriptor_b rhpdb_checker rhpdb_checker_inst (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .port_power_state_o,
  .attached_device_fixed_o, .per_port_switch_select_o);

// [dv/host_bus_model.sv]
`timescale 1ns/100ps
// ==========================================
// Host software on the classic bus
module host_bus_model (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request
  output logic cyc_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  output logic timeout_o
);
  initial {cyc_o, we_o, adr_o, sel_o, dat_o, timeout_o} = '0;
  // Held until ack; the first edge waited gives the idle cycle between accesses
  task automatic access(input logic w, input logic [7:0] idx, input logic [3:0] s,
    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'h0};
    sel_o <= s;
    dat_o <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 50);
    rd = dat_i;
    cyc_o <= 1'b0;
    if (ack_i !== 1'b1) timeout_o <= 1'b1;
  endtask : access
endmodule : host_bus_model

// [dv/testbench.sv]
`timescale 1ns/100ps
// ==========================================
// Self-checking bench
module testbench;
  logic clk_i;
  logic rst_i;
  logic cyc_w, we_w, ack_w, to_w, psel_w;
  logic [9:0] adr_w;
  logic [3:0] sel_w;
  logic [31:0] wdat_w, rdat_w, rd;
  logic [2:1] pwr_w, fix_w;
  int n_errors = 0;
  int total_checks = 0;
  // 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Non-zero reset values show that bit 0 is dropped
  root_hub_port_descriptor_b #(.MASK_RESET(3'h7), .FIXED_RESET(3'h5))
    root_hub_port_descriptor_b_inst (.clk_i, .rst_i, .cyc_i(cyc_w), .stb_i(cyc_w),
    .we_i(we_w), .adr_i(adr_w), .sel_i(sel_w), .dat_i(wdat_w), .dat_o(rdat_w), .ack_o(ack_w),
    .port_power_state_o(pwr_w), .attached_device_fixed_o(fix_w), .per_port_switch_select_o(psel_w));
  host_bus_model host_bus_model_inst (.clk_i, .ack_i(ack_w), .dat_i(rdat_w), .cyc_o(cyc_w),
    .we_o(we_w), .adr_o(adr_w), .sel_o(sel_w), .dat_o(wdat_w), .timeout_o(to_w));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [3:0] s, input logic [31:0] d);
    host_bus_model_inst.access(1'b1, idx, s, d, rd);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    host_bus_model_inst.access(1'b0, idx, 4'hF, 32'h0, rd);
    check(rd, exp);
  endtask : rd_chk
  // Command pulse lands on the port output two edges after the edge that raises ack
  task automatic cmd(input logic [31:0] c, input logic [2:1] exp);
    wr(8'hA1, 4'hF, c);
    repeat (4) @(posedge clk_i);
    check(pwr_w, exp);
  endtask : cmd
  task automatic test_reset_fields();
    rd_chk(8'h13, 32'h0006_0004);
    check(fix_w, 2'h2);
    rd_chk(8'h20, 32'h0);
  endtask : test_reset_fields
  task automatic test_field_access();
    wr(8'h93, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h13, 32'h0006_0006);
    wr(8'h93, 4'h1, 32'h0);
    rd_chk(8'h13, 32'h0006_0000);
    check(fix_w, 2'h0);
    wr(8'h93, 4'hF, 32'h0002_0004);
    rd_chk(8'h13, 32'h0002_0004);
    check(fix_w, 2'h2);
    rd_chk(8'h3F, 32'h0);
  endtask : test_field_access
  // Port one masked, port two not
  task automatic test_power_modes();
    cmd(32'h1, 2'h3);
    cmd(32'h2, 2'h0);
    wr(8'hA0, 4'hF, 32'h1);
    check(psel_w, 1'b1);
    cmd(32'h1, 2'h2);
    cmd(32'h20, 2'h3);
    rd_chk(8'h21, 32'h0000_0006);
    cmd(32'h2, 2'h1);
    cmd(32'h40, 2'h1);
    cmd(32'h200, 2'h0);
  endtask : test_power_modes
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // A stuck bus ends the run
  always @(posedge to_w)
  begin
    n_errors++;
    summarize();
  end
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_fields();
    test_field_access();
    test_power_modes();
    summarize();
  end
endmodule : testbench
